// ===== pkg/iocfg_params.svh
// Constants of the interrupt-controller configuration function.
// Assumes inclusion by the design modules by bare name.
`ifndef IOCFG_PARAMS_SVH
`define IOCFG_PARAMS_SVH
`define IOCFG_OFF_PIN_ID 8'h3D
`define IOCFG_OFF_ALTWIN 8'h40
`define IOCFG_OFF_EXPCAP 8'h44
`define IOCFG_OFF_IDXSEL 8'h80
`define IOCFG_OFF_DATAWIN 8'h90
`define IOCFG_OFF_ROUTE 8'hA0
`define IOCFG_OFF_PWRCAP 8'hE0
`define IOCFG_WIN_EN_BIT 15
`define IOCFG_WIN_TOP 12'hFEC
`define IOCFG_ALTWIN_MASK 16'h8FFF
`define IOCFG_ALTWIN_RST 16'h0000
`define IOCFG_IDX_RST 8'h00
`define IOCFG_ROUTE_MASK 32'h0000_0551
`define IOCFG_ROUTE_RST 32'h0000_0000
`define IOCFG_EXP_PORT_TYPE 4'h9
`define IOCFG_EXP_VERSION 4'h1
`define IOCFG_EXP_NEXT 8'hE0
`define IOCFG_EXP_ID 8'h10
`define IOCFG_PM_VER_RST 3'h3
`define IOCFG_PM_VER_LSB 16
`define IOCFG_PM_ID 8'h01
`define IOCFG_PM_NEXT 8'h00
`define IOCFG_PM_STATE_D3 2'h3
`define IOCFG_RT_P3C_BIT 10
`define IOCFG_RT_P3A_BIT 8
`define IOCFG_RT_P2C_BIT 6
`define IOCFG_RT_P2A_BIT 4
`define IOCFG_RT_P0_BIT 0
`define IOCFG_E_P3C_CLR 5'd21
`define IOCFG_E_P3C_SET 5'd19
`define IOCFG_E_P3A_CLR 5'd20
`define IOCFG_E_P3A_SET 5'd17
`define IOCFG_E_P2C_CLR 5'd13
`define IOCFG_E_P2C_SET 5'd11
`define IOCFG_E_P2A_CLR 5'd12
`define IOCFG_E_P2A_SET 5'd9
`define IOCFG_E_P0_CLR 5'd1
`define IOCFG_E_P0_SET 5'd3
`endif

// ===== pkg/iocfg_pkg.sv
// Types of the interrupt-controller configuration function.
// Assumes the params header sits beside it on the include path.
package iocfg_pkg;
  // Configuration request from the requester.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } iocfg_cfg_req_t;
  // Memory request probed for the alternate window.
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic main_hit;
  } iocfg_mem_req_t;
  // Per-source entry numbers of the five routed line-B sources.
  typedef struct packed {
    logic [4:0] p3c_line_b_route;
    logic [4:0] p3a_line_b_route;
    logic [4:0] p2c_line_b_route;
    logic [4:0] p2a_line_b_route;
    logic [4:0] p0_line_b_route;
  } iocfg_route_t;
endpackage

// ===== verilog/iocfg_route_map.sv
// Maps routing select bits to redirection-table entry numbers.
// Assumes a registered select word from the configuration function.
`timescale 1ns/10ps
`default_nettype none
`include "iocfg_params.svh"
module iocfg_route_map
  import iocfg_pkg::*;
(
  // Select word
  input wire logic [31:0] sel,
  // Entry numbers
  output iocfg_route_t route
);
  // Each source picks between its two fixed entries.
  always_comb begin
    route.p3c_line_b_route = sel[`IOCFG_RT_P3C_BIT] ? `IOCFG_E_P3C_SET : `IOCFG_E_P3C_CLR;
    route.p3a_line_b_route = sel[`IOCFG_RT_P3A_BIT] ? `IOCFG_E_P3A_SET : `IOCFG_E_P3A_CLR;
    route.p2c_line_b_route = sel[`IOCFG_RT_P2C_BIT] ? `IOCFG_E_P2C_SET : `IOCFG_E_P2C_CLR;
    route.p2a_line_b_route = sel[`IOCFG_RT_P2A_BIT] ? `IOCFG_E_P2A_SET : `IOCFG_E_P2A_CLR;
    route.p0_line_b_route = sel[`IOCFG_RT_P0_BIT] ? `IOCFG_E_P0_SET : `IOCFG_E_P0_CLR;
  end
endmodule
`default_nettype wire

// ===== verilog/iocfg_function.sv
// Configuration registers of the interrupt-controller function.
// Assumes one clock, a synchronous reset and one-cycle request strobes.
//
// How it works
// - Enabled window claims memory, ignoring space enable.
// - Bits 11:8 give address 19:16 under FEC.
// - Bits 7:4 give address 15:12.
// - Bits 3:0 give address 11:8.
// - Index register picks the snapshot entry.
// - Snapshot read returns the indexed entry, zero past ENTRY_COUNT.
// - Bits 10, 8 route port 3 sources.
// - Bits 6, 4 route port 2 sources.
// - Bit 0 routes port 0; all reset zero.
// - Express header reads type 9, version 1.
// - Express header reads ID 10h, next E0h.
// - Light and deeper sleep read unsupported.
// - Power version resets 3, writable once.
// - Power header reads ID 1, next zero.
// - Clock bit and other flags read zero.
// - In D3hot the main claim is blocked; the window and config are served.
// - Write-once field takes only the first write reaching its lane.
`timescale 1ns/10ps
`default_nettype none
`include "iocfg_params.svh"
module iocfg_function
  import iocfg_pkg::*;
#(
  parameter int ENTRY_COUNT = 256
)
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Configuration requests
  input wire iocfg_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  // Memory window probe
  input wire iocfg_mem_req_t mem_req,
  input wire logic mem_space_en,
  input wire logic [1:0] power_state,
  output logic win_claim,
  output logic main_claim,
  output logic [7:0] win_offset,
  // Redirection entry snapshot source
  output logic [7:0] entry_index,
  input wire logic [31:0] entry_data,
  // Routed entry numbers
  output iocfg_route_t route
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks.
  initial begin
    if (ENTRY_COUNT < 1 || ENTRY_COUNT > 256) begin
      $error("ENTRY_COUNT must lie between 1 and 256.");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [15:0] altwin_r;
  logic [7:0] index_pointer_reg;
  logic [31:0] route_sel_r;
  logic [2:0] pm_ver_r;
  logic pm_ver_locked_r;
  logic [31:0] data_window_reg;
  logic [31:0] rdata_nxt;
  logic [31:0] wmask;
  logic [31:0] wr_altwin;
  logic [31:0] wr_route;
  logic [31:0] wr_idx;
  iocfg_route_t route_nxt;
  logic in_d3;
  logic win_hit;
  logic wr_go;
  logic rd_go;

  assign wr_go = clk_en && cfg_req.wr;
  assign rd_go = clk_en && cfg_req.rd;

  // Byte enables widened to a bit mask, one lane per generate pass.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{cfg_req.be[gi]}};
    end
  endgenerate

  // Merged write values, keeping unmasked lanes and dropping reserved bits.
  assign wr_altwin = ((cfg_req.wdata & wmask) | ({16'h0000, altwin_r} & ~wmask))
                     & {16'h0000, `IOCFG_ALTWIN_MASK};
  assign wr_route = ((cfg_req.wdata & wmask) | (route_sel_r & ~wmask))
                    & `IOCFG_ROUTE_MASK;
  assign wr_idx = (cfg_req.wdata & wmask) | ({24'h000000, index_pointer_reg} & ~wmask);

  ////////////////////////////////////////////////////////////////////////
  // Alternate window control register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      altwin_r <= `IOCFG_ALTWIN_RST;
    end else if (wr_go && cfg_req.addr == `IOCFG_OFF_ALTWIN) begin
      altwin_r <= wr_altwin[15:0];
    end
  end

  // Index register for the snapshot path.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      index_pointer_reg <= `IOCFG_IDX_RST;
    end else if (wr_go && cfg_req.addr == `IOCFG_OFF_IDXSEL) begin
      index_pointer_reg <= wr_idx[7:0];
    end
  end

  // Routing select register; all bits clear at reset.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      route_sel_r <= `IOCFG_ROUTE_RST;
    end else if (wr_go && cfg_req.addr == `IOCFG_OFF_ROUTE) begin
      route_sel_r <= wr_route;
    end
  end

  // Power version field: first write reaching its lane locks it.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pm_ver_r <= `IOCFG_PM_VER_RST;
      pm_ver_locked_r <= 1'b0;
    end else if (wr_go && cfg_req.addr == `IOCFG_OFF_PWRCAP && cfg_req.be[2]
                 && !pm_ver_locked_r) begin
      pm_ver_r <= cfg_req.wdata[`IOCFG_PM_VER_LSB +: 3];
      pm_ver_locked_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Snapshot: the selected entry is sampled every enabled cycle.
  assign entry_index = index_pointer_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      data_window_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      data_window_reg <= (32'(index_pointer_reg) < 32'(ENTRY_COUNT)) ? entry_data
                         : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data assembly.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (cfg_req.addr)
      `IOCFG_OFF_PIN_ID: rdata_nxt = 32'h0000_0000;
      `IOCFG_OFF_ALTWIN: rdata_nxt = {16'h0000, altwin_r};
      `IOCFG_OFF_EXPCAP: begin
        rdata_nxt = {8'h00, `IOCFG_EXP_PORT_TYPE, `IOCFG_EXP_VERSION,
                     `IOCFG_EXP_NEXT, `IOCFG_EXP_ID};
      end
      `IOCFG_OFF_IDXSEL: rdata_nxt = {24'h000000, index_pointer_reg};
      `IOCFG_OFF_DATAWIN: rdata_nxt = data_window_reg;
      `IOCFG_OFF_ROUTE: rdata_nxt = route_sel_r;
      `IOCFG_OFF_PWRCAP: begin
        // Sleep support, clock and other flags read zero.
        rdata_nxt = {13'h0000, pm_ver_r, `IOCFG_PM_NEXT, `IOCFG_PM_ID};
      end
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Registered read answer, one cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_ack <= 1'b0;
    end else if (clk_en) begin
      cfg_ack <= cfg_req.rd || cfg_req.wr;
      cfg_rdata <= rd_go ? rdata_nxt : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory decode: FEC top, then the three selected nibbles.
  assign in_d3 = (power_state == `IOCFG_PM_STATE_D3);
  assign win_hit = altwin_r[`IOCFG_WIN_EN_BIT]
                   && mem_req.addr[31:20] == `IOCFG_WIN_TOP
                   && mem_req.addr[19:16] == altwin_r[11:8]
                   && mem_req.addr[15:12] == altwin_r[7:4]
                   && mem_req.addr[11:8] == altwin_r[3:0];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      win_claim <= 1'b0;
      main_claim <= 1'b0;
      win_offset <= 8'h00;
    end else if (clk_en) begin
      // Window claim ignores space enable and power state.
      win_claim <= mem_req.valid && win_hit;
      main_claim <= mem_req.valid && !win_hit && mem_req.main_hit
                    && mem_space_en && !in_d3;
      win_offset <= mem_req.addr[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Routing outputs, registered.
  iocfg_route_map u_route_map (
    .sel(route_sel_r),
    .route(route_nxt)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      route <= '{`IOCFG_E_P3C_CLR, `IOCFG_E_P3A_CLR, `IOCFG_E_P2C_CLR,
                 `IOCFG_E_P2A_CLR, `IOCFG_E_P0_CLR};
    end else if (clk_en) begin
      route <= route_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== tb/iocfg_function_props.sv
// Checker for the configuration function, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module iocfg_function_props
  import iocfg_pkg::*;
#(parameter int ENTRY_COUNT = 256)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Watched ports
  input wire iocfg_cfg_req_t cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire iocfg_mem_req_t mem_req,
  input wire logic [1:0] power_state,
  input wire logic win_claim,
  input wire logic main_claim,
  input wire logic [7:0] win_offset,
  input wire logic [7:0] entry_index,
  input wire logic [31:0] entry_data,
  input wire iocfg_route_t route
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Taken reads and index writes.
  wire logic rd_go = clk_en && cfg_req.rd;
  wire logic wr_idx = clk_en && cfg_req.wr && cfg_req.addr == 8'h80 && cfg_req.be[0];
  a_win_top_range: assert property ($past(clk_en) && win_claim |-> $past(mem_req.addr[31:20]) == 12'hFEC)
    else $error("window claim outside top range");
  a_win_byte_offset: assert property ($past(clk_en) && win_claim |-> win_offset == $past(mem_req.addr[7:0]))
    else $error("window offset wrong");
  a_d3_main_blocked: assert property ($past(clk_en) && main_claim |-> $past(power_state) != 2'h3)
    else $error("main claim in deep sleep");
  a_route_port3: assert property (route.p3c_line_b_route inside {5'd21, 5'd19} && route.p3a_line_b_route inside {5'd20, 5'd17})
    else $error("port 3 route entry wrong");
  a_route_low_ports: assert property (route.p2c_line_b_route inside {5'd13, 5'd11} && route.p2a_line_b_route inside {5'd12, 5'd9} && route.p0_line_b_route inside {5'd1, 5'd3})
    else $error("low port route entry wrong");
  a_index_write: assert property (wr_idx |=> entry_index == $past(cfg_req.wdata[7:0]))
    else $error("index not written");
  a_express_header: assert property (rd_go && cfg_req.addr == 8'h44 |=> cfg_rdata == 32'h0091_E010)
    else $error("express header wrong");
  a_power_header: assert property (rd_go && cfg_req.addr == 8'hE0 |=> cfg_rdata[31:19] == 13'h0 && cfg_rdata[15:0] == 16'h0001)
    else $error("power header wrong");
  a_snap_read: assert property (rd_go && cfg_req.addr == 8'h90 && $stable(entry_data) && $past(clk_en) && !$past(reset) && entry_index < ENTRY_COUNT |=> cfg_rdata == $past(entry_data))
    else $error("snapshot data wrong");
  // Main scenarios seen.
  c_win: cover property (win_claim);
  c_main: cover property (main_claim);
  c_snap: cover property (rd_go && cfg_req.addr == 8'h90);
endmodule
bind iocfg_function iocfg_function_props #(.ENTRY_COUNT(ENTRY_COUNT)) u_props (.sys_clk, .reset,
  .clk_en, .cfg_req, .cfg_rdata, .mem_req, .power_state, .win_claim, .main_claim, .win_offset,
  .entry_index, .entry_data, .route);
`default_nettype wire

// ===== tb/iocfg_table_model.sv
// Redirection table behind the snapshot source port.
// Assumes the index comes straight from the index register.
`timescale 1ns/10ps
`default_nettype none
module iocfg_table_model (
  // Index in
  input wire logic [7:0] entry_index,
  // Entry out
  output logic [31:0] entry_data
);
  // Each entry is a pattern of its index, so a wrong index shows.
  assign entry_data = {entry_index, ~entry_index, 8'hC3, entry_index ^ 8'h5A};
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the configuration function.
// Assumes the table model drives the snapshot source.
`timescale 1ns/10ps
`default_nettype none
module tb
  import iocfg_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  iocfg_cfg_req_t cfg_req = '0;
  iocfg_mem_req_t mem_req = '0;
  logic mem_space_en = 1'b0;
  logic [1:0] power_state = 2'h0;
  logic [31:0] cfg_rdata, entry_data, rd_val;
  logic cfg_ack, win_claim, main_claim;
  logic [7:0] win_offset, entry_index;
  iocfg_route_t route;
  int fail_count = 0;
  int n_compared = 0;
  iocfg_function DUT (.sys_clk, .reset, .clk_en, .cfg_req, .cfg_rdata, .cfg_ack, .mem_req,
    .mem_space_en, .power_state, .win_claim, .main_claim, .win_offset, .entry_index,
    .entry_data, .route);
  iocfg_table_model u_table (.entry_index, .entry_data);
  // Clock of 40 ns period.
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // One configuration cycle; a missing acknowledge spoils the read value.
  task automatic cfg_rw(input logic wr, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] wd);
    @(posedge sys_clk);
    #1;
    cfg_req = '{rd: ~wr, wr: wr, addr: a, be: be, wdata: wd};
    @(posedge sys_clk);
    #1;
    cfg_req = '0;
    rd_val = (cfg_ack === 1'b1) ? cfg_rdata : 'x;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    cfg_rw(1'b0, a, 4'h0, 32'h0);
    check(what, rd_val, exp);
  endtask
  // One memory probe; expects {window claim, main claim}.
  task automatic probe(input logic [31:0] a, input logic hit, input logic [1:0] ps,
    input logic [1:0] exp);
    @(posedge sys_clk);
    #1;
    mem_req = '{valid: 1'b1, addr: a, main_hit: hit};
    power_state = ps;
    @(posedge sys_clk);
    #1;
    mem_req = '0;
    check("claims", {win_offset, win_claim, main_claim}, {a[7:0], exp});
  endtask
  task automatic final_report;
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    logic [7:0] idx;
    repeat (2) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    rd_chk("pin", 8'h3D, 32'h0);
    rd_chk("win", 8'h40, 32'h0);
    rd_chk("exp", 8'h44, 32'h0091_E010);
    rd_chk("idx", 8'h80, 32'h0);
    rd_chk("route_reg", 8'hA0, 32'h0);
    rd_chk("pm", 8'hE0, 32'h0003_0001);
    check("route", route, {5'd21, 5'd20, 5'd13, 5'd12, 5'd1});
    cfg_rw(1'b1, 8'h50, 4'hF, '1);
    rd_chk("unmapped", 8'h50, 32'h0);
    cfg_rw(1'b1, 8'h44, 4'hF, '1);
    rd_chk("exp", 8'h44, 32'h0091_E010);
    cfg_rw(1'b1, 8'hA0, 4'hF, '1);
    rd_chk("route_reg", 8'hA0, 32'h551);
    check("route", route, {5'd19, 5'd17, 5'd11, 5'd9, 5'd3});
    cfg_rw(1'b1, 8'h40, 4'hF, 32'hFFFF_F123);
    rd_chk("win", 8'h40, 32'h8123);
    probe(32'hFEC1_2345, 1'b0, 2'h0, 2'b10);
    probe(32'hFEC1_2445, 1'b0, 2'h0, 2'b00);
    probe(32'hFEC1_3345, 1'b0, 2'h0, 2'b00);
    probe(32'hFEC2_2345, 1'b0, 2'h0, 2'b00);
    probe(32'hFED1_2345, 1'b0, 2'h0, 2'b00);
    probe(32'hFEC1_23FF, 1'b1, 2'h3, 2'b10);
    mem_space_en = 1'b1;
    probe(32'h1000_0010, 1'b1, 2'h0, 2'b01);
    probe(32'h1000_0010, 1'b1, 2'h3, 2'b00);
    cfg_rw(1'b1, 8'h40, 4'hF, 32'h0123);
    probe(32'hFEC1_2345, 1'b0, 2'h0, 2'b00);
    // Snapshot path at a middle and the top index.
    for (int i = 0; i < 2; i++) begin
      idx = (i == 0) ? 8'h5A : 8'hFF;
      cfg_rw(1'b1, 8'h80, 4'h1, {24'h0, idx});
      check("index", entry_index, idx);
      repeat (2) @(posedge sys_clk);
      rd_chk("snap", 8'h90, {idx, ~idx, 8'hC3, idx ^ 8'h5A});
    end
    // A write while the clock enable is low must not be taken.
    clk_en = 1'b0;
    cfg_rw(1'b1, 8'h80, 4'h1, 32'h0000_0033);
    clk_en = 1'b1;
    check("index frozen", entry_index, 8'hFF);
    cfg_rw(1'b1, 8'hE0, 4'hF, 32'hFFFA_FFFF);
    rd_chk("pm", 8'hE0, 32'h0002_0001);
    cfg_rw(1'b1, 8'hE0, 4'hF, '1);
    rd_chk("pm", 8'hE0, 32'h0002_0001);
    @(posedge sys_clk);
    #1;
    reset = 1'b1;
    @(posedge sys_clk);
    #1;
    reset = 1'b0;
    rd_chk("pm", 8'hE0, 32'h0003_0001);
    final_report;
  end
  // Watchdog against a hang.
  initial begin
    #100000;
    fail_count++;
    final_report;
  end
endmodule
`default_nettype wire
